/* File: inc/dcvs_pkg.sv */
// shared constants for the configuration-variable store and function outputs
package dcvs_pkg;
   // store geometry
   localparam int          DCVS_CV_WIDTH    = 8;    // one byte per variable
   localparam int          DCVS_ADDR_WIDTH  = 8;    // variable index width
   localparam int          DCVS_CV_DEPTH    = 256;  // number of variables
   // variable indices
   localparam logic [7:0]  DCVS_ADDR_CV     = 8'h01; // primary address variable
   localparam logic [7:0]  DCVS_ACCEL_CV    = 8'h03; // acceleration_rate
   localparam logic [7:0]  DCVS_BASIC_CV    = 8'h1d; // basic_configuration_bits
   // factory reset values
   localparam logic [7:0]  DCVS_ADDR_RESET  = 8'h03; // locomotive number 3
   localparam logic [7:0]  DCVS_ACCEL_RESET = 8'h00; // no momentum
   localparam logic [7:0]  DCVS_BASIC_RESET = 8'h02; // 28 steps, no table
   // fields of basic_configuration_bits
   localparam int          DCVS_BIT_STEPS28 = 1;    // 28 speed-step mode
   localparam int          DCVS_BIT_SPDTBL  = 4;    // user speed table
   // function key numbers of the default map
   localparam int          DCVS_KEY_LAMP    = 0;
   localparam int          DCVS_KEY_XING    = 2;
   localparam int          DCVS_KEY_AUX5    = 5;
   localparam int          DCVS_KEY_AUX6    = 6;
   localparam int          DCVS_KEY_DIM     = 7;
   localparam int          DCVS_KEY_BRAKE   = 11;
   localparam int          DCVS_NUM_KEYS    = 13;
   // lamp brightness codes
   localparam logic [7:0]  DCVS_LAMP_FULL   = 8'hff;
   localparam logic [7:0]  DCVS_LAMP_DIM    = 8'h40;
   localparam logic [7:0]  DCVS_LAMP_OFF    = 8'h00;
   // acknowledge load pulse: 5 ms at 4 ns
   localparam int          DCVS_ACK_MS      = 5;
   localparam int          DCVS_CLK_NS      = 4;
   localparam int          DCVS_ACK_CYCLES  = (DCVS_ACK_MS * 1000000 + DCVS_CLK_NS - 1)
                                              / DCVS_CLK_NS;
endpackage

/* File: rtl/dcvs_mem.sv */
// byte-wide variable memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module dcvs_mem #(
   parameter int AW = 8,   // index width
   parameter int DW = 8    // data width
) (
   input  wire logic          clk_sys,  // system clock
   input  wire logic          wr_en,    // write strobe
   input  wire logic [AW-1:0] wr_addr,  // write index
   input  wire logic [DW-1:0] wr_data,  // write byte
   input  wire logic [AW-1:0] rd_addr,  // read index
   output logic      [DW-1:0] rd_data   // registered read byte
);
   logic [DW-1:0] mem [0:(1<<AW)-1];  // storage array, no reset

   // write replaces, read is one cycle late
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

/* File: rtl/dcvs_top.sv */
// configuration-variable store with default function map and lamp logic
//
// Function
// - factory default answers locomotive number 3
// - key zero switches the lit lamp on/off
// - direction picks front or rear lamp
// - key seven dims the front lamp
// - default map for crossing, aux, braking
// - stored values persist, any rewrite replaces (the steering shadows of variables 1, 3 and 29 reload factory values at reset)
// - each variable is eight bits, 0..255
// - variable 3 is whole-byte acceleration rate
// - bit-packed variables: independent bit controls
// - variable 29 bits: speed table, 28 steps
// - bit n carries weight two to n
// - acknowledge by motor load for 5 ms
`timescale 1ns/1ns
`default_nettype none
module dcvs_top
   import dcvs_pkg::*;
#(
   parameter int ACK_CYCLES = DCVS_ACK_CYCLES  // acknowledge pulse length
) (
   input  wire logic                     clk_sys,        // system clock
   input  wire logic                     reset_n,        // async reset, low
   input  wire logic                     cv_wr,          // variable write strobe
   input  wire logic                     cv_rd,          // variable read strobe
   input  wire logic [DCVS_ADDR_WIDTH-1:0] cv_index,     // variable index
   input  wire logic [DCVS_CV_WIDTH-1:0] cv_wdata,       // byte to write
   input  wire logic                     service_mode,   // programming track
   input  wire logic [7:0]               pkt_address,    // command address
   input  wire logic                     pkt_valid,      // control command strobe
   input  wire logic                     pkt_forward,    // direction in command
   input  wire logic [DCVS_NUM_KEYS-1:0] pkt_keys,       // function key states
   output logic      [DCVS_CV_WIDTH-1:0] cv_rdata,       // read byte
   output logic                          cv_rvalid,      // read byte valid
   output logic      [7:0]               front_lamp,     // front lamp level
   output logic      [7:0]               rear_lamp,      // rear lamp level
   output logic                          crossing_fx,    // crossing effect on
   output logic                          aux_effect_output_five, // aux 5
   output logic                          aux_effect_output_six,  // aux 6
   output logic                          motor_brake,    // braking active
   output logic                          ack_load,       // motor ack pulse
   output logic      [7:0]               accel_rate,     // acceleration rate
   output logic                          speed_table_en, // speed table on
   output logic                          steps_28        // 28 step mode
);
   // shadow copies of the variables that steer logic; the array itself
   // stands for the non-volatile store, kept across reset
   logic [7:0] loco_address;            // primary address shadow
   logic [7:0] acceleration_rate;       // shadow of variable 3
   logic [7:0] basic_configuration_bits; // shadow of variable 29
   logic [DCVS_CV_WIDTH-1:0] mem_rdata; // memory read byte
   logic       rd_pend;                 // read in flight
   // sized from the parameter so a longer pulse never wraps the counter
   logic [$clog2(ACK_CYCLES+1)-1:0] ack_cnt; // pulse down-counter
   logic       fwd;                     // latched direction
   logic [DCVS_NUM_KEYS-1:0] keys;      // latched key states

   // bit weight helper: bit n of a byte counts two to n
   function automatic logic bit_of(input logic [7:0] v, input int n);
      bit_of = v[n];
   endfunction

   // decode of the incoming strobes
   wire ours       = pkt_valid && (pkt_address == loco_address);
   wire wr_addr_cv = cv_wr && (cv_index == DCVS_ADDR_CV);
   wire wr_accel   = cv_wr && (cv_index == DCVS_ACCEL_CV);
   wire wr_basic   = cv_wr && (cv_index == DCVS_BASIC_CV);
   wire ack_start  = service_mode && (cv_wr || cv_rd);
   wire lamp_on    = keys[DCVS_KEY_LAMP];
   wire dim_on     = keys[DCVS_KEY_DIM];
   // front lamp level: full, dimmed or dark
   wire [7:0] next_front = (lamp_on && fwd) ? (dim_on ? DCVS_LAMP_DIM : DCVS_LAMP_FULL)
                                           : DCVS_LAMP_OFF;
   wire [7:0] next_rear  = (lamp_on && !fwd) ? DCVS_LAMP_FULL : DCVS_LAMP_OFF;

   dcvs_mem #(
      .AW (DCVS_ADDR_WIDTH),
      .DW (DCVS_CV_WIDTH)
   ) u_mem (
      .clk_sys (clk_sys),
      .wr_en   (cv_wr),
      .wr_addr (cv_index),
      .wr_data (cv_wdata),
      .rd_addr (cv_index),
      .rd_data (mem_rdata)
   );

   // shadow registers of steering variables
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         loco_address             <= DCVS_ADDR_RESET;
         acceleration_rate        <= DCVS_ACCEL_RESET;
         basic_configuration_bits <= DCVS_BASIC_RESET;
      end else begin
         if (wr_addr_cv) begin
            loco_address <= cv_wdata;
         end
         if (wr_accel) begin
            acceleration_rate <= cv_wdata;
         end
         if (wr_basic) begin
            basic_configuration_bits <= cv_wdata;
         end
      end
   end

   // read handshake, data two cycles after the strobe
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rd_pend   <= 1'b0;
         cv_rvalid <= 1'b0;
         cv_rdata  <= 8'h00;
      end else begin
         rd_pend   <= cv_rd && !cv_wr;
         cv_rvalid <= rd_pend;
         if (rd_pend) begin
            cv_rdata <= mem_rdata;
         end
      end
   end

   // latch control commands addressed to us
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fwd  <= 1'b1;
         keys <= '0;
      end else if (ours) begin
         fwd  <= pkt_forward;
         keys <= pkt_keys;
      end
   end

   // function outputs, registered
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         front_lamp             <= DCVS_LAMP_OFF;
         rear_lamp              <= DCVS_LAMP_OFF;
         crossing_fx            <= 1'b0;
         aux_effect_output_five <= 1'b0;
         aux_effect_output_six  <= 1'b0;
         motor_brake            <= 1'b0;
      end else begin
         front_lamp             <= next_front;
         rear_lamp              <= next_rear;
         crossing_fx            <= keys[DCVS_KEY_XING];
         aux_effect_output_five <= keys[DCVS_KEY_AUX5];
         aux_effect_output_six  <= keys[DCVS_KEY_AUX6];
         motor_brake            <= keys[DCVS_KEY_BRAKE];
      end
   end

   // configuration outputs decoded from the shadows
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         accel_rate     <= DCVS_ACCEL_RESET;
         speed_table_en <= 1'b0;
         steps_28       <= 1'b0;
      end else begin
         accel_rate     <= acceleration_rate;
         speed_table_en <= bit_of(basic_configuration_bits, DCVS_BIT_SPDTBL);
         steps_28       <= bit_of(basic_configuration_bits, DCVS_BIT_STEPS28);
      end
   end

   // acknowledge pulse; a new access restarts the full length
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ack_cnt  <= '0;
         ack_load <= 1'b0;
      end else begin
         if (ack_start) begin
            ack_cnt  <= ($bits(ack_cnt))'(ACK_CYCLES - 1);
            ack_load <= 1'b1;
         end else if (ack_cnt != '0) begin
            ack_cnt  <= ack_cnt - 1'b1;
         end else begin
            ack_load <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/dcvs_properties.sv */
// assertions on the variable store and function outputs
`timescale 1ns/1ns
`default_nettype none
module dcvs_properties
   import dcvs_pkg::*;
#(parameter int ACK_CYCLES = 10) (
   input wire logic        clk_sys,      // clock
   input wire logic        reset_n,      // reset
   input wire logic        cv_wr,        // write
   input wire logic        cv_rd,        // read
   input wire logic [7:0]  cv_index,     // index
   input wire logic [7:0]  cv_wdata,     // data
   input wire logic        service_mode, // ack mode
   input wire logic [7:0]  pkt_address,  // address
   input wire logic        pkt_valid,    // strobe
   input wire logic        pkt_forward,  // direction
   input wire logic [12:0] pkt_keys,     // keys
   input wire logic        cv_rvalid,    // read valid
   input wire logic [7:0]  front_lamp,   // front
   input wire logic [7:0]  rear_lamp,    // rear
   input wire logic        crossing_fx,  // crossing
   input wire logic        aux_effect_output_five, // aux 5
   input wire logic        aux_effect_output_six,  // aux 6
   input wire logic        motor_brake,  // brake
   input wire logic        ack_load,     // ack pulse
   input wire logic [7:0]  accel_rate,   // accel
   input wire logic        speed_table_en, // table
   input wire logic        steps_28      // 28 steps
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // address the decoder answers now: factory 3, then variable 1
   logic [7:0] addr_now;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         addr_now <= 8'h03;
      end else if (cv_wr && cv_index == 8'h01) begin
         addr_now <= cv_wdata;
      end
   end
   // command for the current address
   wire logic hit = pkt_valid && pkt_address == addr_now;
   sequence quiet3; !hit [*3]; endsequence
   sequence read_req; cv_rd && !cv_wr; endsequence
   front_full_a:
   assert property (hit && pkt_keys[0] && pkt_forward && !pkt_keys[7] |-> ##2 front_lamp == 8'hff)
      else $error("front lamp not full");
   front_dim_a:
   assert property (hit && pkt_keys[0] && pkt_forward && pkt_keys[7] |-> ##2 front_lamp == 8'h40)
      else $error("front lamp not dimmed");
   rear_lamp_a:
   assert property (hit && pkt_keys[0] && !pkt_forward |-> ##2 {front_lamp, rear_lamp} == 16'h00ff)
      else $error("reverse lamp wrong");
   fx_map_a:
   assert property (hit |-> ##2 {crossing_fx, aux_effect_output_five, aux_effect_output_six,
      motor_brake} == $past({pkt_keys[2], pkt_keys[5], pkt_keys[6], pkt_keys[11]}, 2))
      else $error("effect map wrong");
   foreign_addr_a:
   assert property (quiet3 |-> $stable(front_lamp) && $stable(rear_lamp))
      else $error("lamps moved without command");
   read_answer_a:
   assert property (read_req |-> ##2 cv_rvalid) else $error("read answer missing");
   accel_follow_a:
   assert property (cv_wr && cv_index == 8'h03 |-> ##2 accel_rate == $past(cv_wdata, 2))
      else $error("accel rate not loaded");
   basic_bits_a:
   assert property (cv_wr && cv_index == 8'h1d |-> ##2
      {speed_table_en, steps_28} == $past({cv_wdata[4], cv_wdata[1]}, 2))
      else $error("config bits not loaded");
   ack_pulse_a:
   assert property (service_mode && (cv_wr || cv_rd) |=> ack_load [*8])
      else $error("ack pulse short");
endmodule
bind dcvs_top dcvs_properties #(.ACK_CYCLES(ACK_CYCLES)) u_dcvs_properties (.clk_sys,
   .reset_n, .cv_wr, .cv_rd, .cv_index, .cv_wdata, .service_mode, .pkt_address, .pkt_valid,
   .pkt_forward, .pkt_keys, .cv_rvalid, .front_lamp, .rear_lamp, .crossing_fx,
   .aux_effect_output_five, .aux_effect_output_six, .motor_brake, .ack_load, .accel_rate,
   .speed_table_en, .steps_28);
`default_nettype wire

/* File: sim/dcvs_station.sv */
// command station model: control commands and variable accesses
`timescale 1ns/1ns
`default_nettype none
module dcvs_station (
   input  wire logic  clk_sys,      // clock
   output logic       cv_wr,        // write strobe
   output logic       cv_rd,        // read strobe
   output logic [7:0] cv_index,     // index
   output logic [7:0] cv_wdata,     // byte
   output logic       service_mode, // programming track
   output logic [7:0] pkt_address,  // address
   output logic       pkt_valid,    // command strobe
   output logic       pkt_forward,  // direction
   output logic [12:0] pkt_keys     // key states
);
   initial {cv_wr, cv_rd, cv_index, cv_wdata, service_mode} = '0;
   initial {pkt_address, pkt_valid, pkt_forward, pkt_keys} = '0;
   // one-cycle strobe; released fields flip so stale values never pass
   task automatic cmd(input logic [7:0] a, input logic f, input logic [12:0] k);
      @(negedge clk_sys);
      {pkt_address, pkt_forward, pkt_keys, pkt_valid} = {a, f, k, 1'b1};
      @(negedge clk_sys);
      pkt_valid = 1'b0;
      {pkt_address, pkt_forward, pkt_keys} = ~{pkt_address, pkt_forward, pkt_keys};
   endtask
   task automatic acc(input logic w, s, input logic [7:0] i, d);
      @(negedge clk_sys);
      {cv_wr, cv_rd, service_mode, cv_index, cv_wdata} = {w, !w, s, i, d};
      @(negedge clk_sys);
      {cv_wr, cv_rd} = 2'b00;
      {cv_index, cv_wdata} = ~{cv_index, cv_wdata};
   endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the variable store and function outputs
`timescale 1ns/1ns
`default_nettype none
`define CHECK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", n, e, a); end end
module testbench
   import dcvs_pkg::*;
;
   logic clk_sys = 1'b0, reset_n = 1'b0;
   logic cv_wr, cv_rd, service_mode, pkt_valid, pkt_forward, cv_rvalid, crossing_fx, ack_load;
   logic aux_effect_output_five, aux_effect_output_six, motor_brake, speed_table_en, steps_28;
   logic [7:0] cv_index, cv_wdata, pkt_address, cv_rdata, front_lamp, rear_lamp, accel_rate;
   logic [12:0] pkt_keys;
   int comparisons = 0, mismatches = 0, cycles = 0, n;
   wire logic [19:0] outs = {front_lamp, rear_lamp, crossing_fx, aux_effect_output_five,
      aux_effect_output_six, motor_brake};
   // rows: direction and keys, then front, rear, crossing, aux5, aux6, brake
   logic [13:0] stim [7] = '{14'h2001, 14'h2081, 14'h0001, 14'h2000, 14'h2004, 14'h2820,
      14'h0040};
   logic [19:0] expv [7] = '{20'hff000, 20'h40000, 20'h00ff0, 20'h00000, 20'h00008,
      20'h00005, 20'h00002};
   always #2 clk_sys = ~clk_sys;
   dcvs_top #(.ACK_CYCLES(10)) u_dcvs_top (.clk_sys, .reset_n, .cv_wr, .cv_rd, .cv_index,
      .cv_wdata, .service_mode, .pkt_address, .pkt_valid, .pkt_forward, .pkt_keys, .cv_rdata,
      .cv_rvalid, .front_lamp, .rear_lamp, .crossing_fx, .aux_effect_output_five,
      .aux_effect_output_six, .motor_brake, .ack_load, .accel_rate, .speed_table_en, .steps_28);
   dcvs_station u_station (.clk_sys, .cv_wr, .cv_rd, .cv_index, .cv_wdata, .service_mode,
      .pkt_address, .pkt_valid, .pkt_forward, .pkt_keys);
   // write then read back; answer stands one edge after the strobe drops
   task automatic wr_rd(input logic [7:0] i, d, input logic s);
      u_station.acc(1'b1, s, i, d);
      u_station.acc(1'b0, s, i, 8'h00);
      repeat (1) @(posedge clk_sys);
      #1 `CHECK("read back", {1'b1, d}, {cv_rvalid, cv_rdata})
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hang guard, far beyond the hundred-odd cycles needed
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(negedge clk_sys);
      reset_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 `CHECK("reset config", 10'h001, {accel_rate, speed_table_en, steps_28})
      $display("test reset done");
      for (n = 0; n < 7; n++) begin
         u_station.cmd(8'h03, stim[n][13], stim[n][12:0]);
         repeat (2) @(posedge clk_sys);
         #1 `CHECK("outputs", expv[n], outs)
      end
      $display("test key map done");
      // another address must leave outputs alone
      u_station.cmd(8'h04, 1'b1, 13'h0001);
      repeat (2) @(posedge clk_sys);
      #1 `CHECK("foreign address", 20'h00002, outs)
      wr_rd(8'h03, 8'hff, 1'b0);
      `CHECK("accel max", 8'hff, accel_rate)
      `CHECK("ack idle", 1'b0, ack_load)
      wr_rd(8'h03, 8'h00, 1'b0);
      `CHECK("accel min", 8'h00, accel_rate)
      wr_rd(8'h1d, 8'h12, 1'b0);
      `CHECK("table and steps", 2'b11, {speed_table_en, steps_28})
      wr_rd(8'h1d, 8'h10, 1'b0);
      `CHECK("table only", 2'b10, {speed_table_en, steps_28})
      for (n = 0; n < 8; n++)
         wr_rd(8'h20, 8'h01 << n, 1'b0);
      // a rewritten address moves the decoder to the new number
      wr_rd(8'h01, 8'h05, 1'b0);
      u_station.cmd(8'h05, 1'b1, 13'h0001);
      repeat (2) @(posedge clk_sys);
      #1 `CHECK("new address", 20'hff000, outs)
      u_station.cmd(8'h03, 1'b0, 13'h0001);
      repeat (2) @(posedge clk_sys);
      #1 `CHECK("old address", 20'hff000, outs)
      $display("test store done");
      // ack pulse holds ten cycles from the read edge, dropping nine edges after the read answer
      wr_rd(8'h40, 8'h5a, 1'b1);
      // already high for the cycle since the read edge
      n = 1;
      while (ack_load === 1'b1 && n < 50) begin
         @(posedge clk_sys);
         #1 n++;
      end
      `CHECK("ack length", 10, n)
      $display("test ack done");
      conclude();
   end
endmodule
`default_nettype wire
